// file: dmc_defines.svh
// Purpose: constants for the DAC update and monitor control block
// Assumes: 100 MHz clock
// Notes:   times in ns, counts derived by truncating integer division
`ifndef DMC_DEFINES_SVH
`define DMC_DEFINES_SVH
`define DMC_CLK_NS        10
`define DMC_RESET_NS      270000
`define DMC_RESET_CYC     (`DMC_RESET_NS / `DMC_CLK_NS)
`define DMC_CLEAR_NS      32000
`define DMC_CLEAR_CYC     (`DMC_CLEAR_NS / `DMC_CLK_NS)
`define DMC_CALC_CYC      8'h08
`define DMC_POR_CYC       16'h0040
`define DMC_ADDR_CTRL     4'h0
`define DMC_ADDR_CLRCODE  4'h4
`define DMC_ADDR_CMD      4'h8
`define DMC_ADDR_STATUS   4'hC
`define DMC_ADDR_MONSEL   4'h0
`define DMC_SFR_MONITOR   5'h0A
`define DMC_SFR_CLRCODE   5'h01
`define DMC_SFR_PDOWN     5'h08
`define DMC_SFR_PUP       5'h09
`define DMC_SFR_CTRL      5'h0C
`define DMC_MON_OFF       6'h3F
`define DMC_MON_EXT_LO    6'h22
`define DMC_MON_EXT_HI    6'h25
`define DMC_CH_LAST       6'h1F
`define DMC_GAIN_FULL     12'hFFE
`define DMC_OFFS_ZERO     12'h800
`define DMC_CTRL_RESET    12'h800
`define DMC_FIFO_DEPTH    128
`define DMC_CR_MONEN      7
`define DMC_CR_PDHIZ      11
`endif

// file: dmc_pkg.sv
// Purpose: types for the DAC update and monitor control block
// Assumes: nothing
// Notes:   command word is 20 bits
package dmc_pkg;
   typedef struct packed {
      logic       readNotWrite;
      logic       registerSelectHigh;
      logic       registerSelectLow;
      logic [4:0] channelAddressField;
      logic [11:0] data;
   } dmc_cmd_t;
   typedef enum logic [4:0] {
      ST_POR   = 5'h01,
      ST_IDLE  = 5'h02,
      ST_CALC  = 5'h04,
      ST_RESET = 5'h08,
      ST_CLEAR = 5'h10
   } dmc_state_t;
endpackage

// file: dmc_core.sv
// Overview of operation
// - Register select 00 with address 01010 is the monitor-select command.
// - Monitor source address is data bits 11..6; bits 5..0 ignored.
// - Monitor routes only when monitor enable bit set.
// - Monitor source 63 makes the monitor output high impedance.
// - 0..31 pick DAC channels, 34..37 external inputs; others undefined.
// - Each falling edge of reset pin restores power-on register values.
// - Reset sets gain full scale, offset zero, DAC registers zero.
// - Busy low for reset sequence, at most 270 us, then high.
// - During reset sequence host writes and load strobes discarded.
// - After reset, pin level ignored until next falling edge.
// - Clear pin low loads all DAC registers with the clear code.
// - Hardware clear completes within 32 us.
// - Data, gain or offset write recomputes corrected value, busy low.
// - Writes accepted while computing; no DAC update until busy high.
// - Load strobe during computation remembered, applied when busy rises.
// - Load strobe held low updates DACs each time busy rises.
// - Load copies only channels whose corrected value changed since last; code copies every recomputed channel, changed or not.
// - Queue-enable pin sampled at power-up and after clear or reset.
// - FIFO used only in parallel mode; host ties pin low otherwise.
// - FIFO holds 128 commands; writes while full are dropped.
// - Power-on sequence sets registers, outputs high impedance, busy low.
// - Power-down keeps registers; amplifiers high-Z or 100k per config.
// - Monitor enable resets to 0; monitor stays high-Z while 0.
// - Clear code resets to zero until host writes it.
//
// Purpose: command decode, busy, load and monitor control of a 32 ch DAC
// Assumes: commands arrive over Avalon-MM at CMD offset
// Notes:   analog parts appear as control outputs only
//
// The implementer's own choices: register access over Avalon-MM and the register addresses.
`timescale 1ns/1ns
`default_nettype none
`include "dmc_defines.svh"
module dmc_core
   import dmc_pkg::*;
#(
   parameter int RESET_CYC = `DMC_RESET_CYC
) (
   input  wire logic        clk,
   input  wire logic        reset,
   input  wire logic [3:0]  avsAddress,
   input  wire logic        avsRead,
   input  wire logic        avsWrite,
   input  wire logic [31:0] avsWriteData,
   output logic      [31:0] avsReadData,
   output logic             avsWaitRequest,
   input  wire logic        resetPin_n,
   input  wire logic        asyncClearInput_n,
   input  wire logic        dacLoadStrobe_n,
   input  wire logic        queueEnablePin,
   input  wire logic        parallelMode,
   input  wire logic        powerDownPin,
   output logic             busy_n,
   output logic      [5:0]  monitorSelect,
   output logic             monitorOutputEnable,
   output logic             amplifierEnable,
   output logic             amplifierLoad,
   output logic             dacWriteStrobe,
   output logic      [4:0]  dacWriteChannel,
   output logic      [11:0] dacWriteData
);
   // Synchronisers for pins
   logic [1:0] rstS;
   logic [1:0] clrS;
   logic [1:0] ldS;
   logic [1:0] qeS;
   logic [1:0] pdS;
   logic [1:0] pmS;
   logic       rstPrev;
   logic       clrPrev;
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         rstS    <= 2'h3;
         clrS    <= 2'h3;
         ldS     <= 2'h3;
         qeS     <= 2'h0;
         pdS     <= 2'h0;
         pmS     <= 2'h0;
         rstPrev <= 1'b1;
         clrPrev <= 1'b1;
      end else begin
         rstS    <= {rstS[0], resetPin_n};
         clrS    <= {clrS[0], asyncClearInput_n};
         ldS     <= {ldS[0], dacLoadStrobe_n};
         qeS     <= {qeS[0], queueEnablePin};
         pdS     <= {pdS[0], powerDownPin};
         pmS     <= {pmS[0], parallelMode};
         rstPrev <= rstS[1];
         clrPrev <= clrS[1];
      end
   end
   logic rstFall;
   logic clrFall;
   logic ldLow;
   assign rstFall = rstPrev & ~rstS[1];
   assign clrFall = clrPrev & ~clrS[1];
   assign ldLow   = ~ldS[1];

   // Channel storage
   logic [11:0] inputData [32];
   logic [11:0] gainReg   [32];
   logic [11:0] offsetReg [32];
   logic [11:0] corrected [32];
   logic [31:0] dirty;
   logic [31:0] pendCalc;
   logic [11:0] clearCode;
   logic [11:0] ctrlReg;
   logic        powerDown;
   logic [5:0]  monSource;

   dmc_state_t  state;
   logic [31:0] timer;
   logic        loadPending;
   logic        qEnabled;
   logic [4:0]  calcCh;
   logic        busyPrev;

   // Command FIFO, one command per entry
   dmc_cmd_t    fifoMem [`DMC_FIFO_DEPTH];
   logic [6:0]  wrPtr;
   logic [6:0]  rdPtr;
   logic [7:0]  fifoCount;
   logic        fifoFull;
   logic        fifoEmpty;
   assign fifoFull  = (fifoCount == 8'(`DMC_FIFO_DEPTH));
   assign fifoEmpty = (fifoCount == 8'h00);

   logic blocked;
   assign blocked = (state == ST_POR) || (state == ST_RESET);

   logic cmdWr;
   assign cmdWr = avsWrite && (avsAddress == `DMC_ADDR_CMD) && !blocked;
   logic useFifo;
   assign useFifo = qEnabled && pmS[1];
   logic push;
   assign push = cmdWr && useFifo && !fifoFull;

   // Execute either the direct write or the head of the FIFO
   logic     execValid;
   dmc_cmd_t execCmd;
   always_comb begin
      if (useFifo) begin
         execValid = !fifoEmpty && !blocked && (state != ST_CLEAR);
         execCmd   = fifoMem[rdPtr];
      end else begin
         execValid = cmdWr;
         execCmd   = avsWriteData[19:0];
      end
   end
   logic pop;
   assign pop = useFifo && execValid;

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         wrPtr     <= 7'h00;
         rdPtr     <= 7'h00;
         fifoCount <= 8'h00;
      end else if (rstFall || clrFall) begin
         wrPtr     <= 7'h00;
         rdPtr     <= 7'h00;
         fifoCount <= 8'h00;
      end else begin
         if (push) begin
            wrPtr <= wrPtr + 7'h01;
         end
         if (pop) begin
            rdPtr <= rdPtr + 7'h01;
         end
         fifoCount <= fifoCount + {7'h00, push} - {7'h00, pop};
      end
   end
   always_ff @(posedge clk) begin
      if (push) begin
         fifoMem[wrPtr] <= avsWriteData[19:0];
      end
   end

   logic isSfr;
   assign isSfr = !execCmd.registerSelectHigh && !execCmd.registerSelectLow;
   logic chWrite;
   // No channel register writes while the powerDown register is set; the power-down pin does not block them
   assign chWrite = execValid && !execCmd.readNotWrite && !isSfr
                    && !powerDown;

   // Per-channel registers and corrected value
   genvar g;
   generate
      for (g = 0; g < 32; g++) begin : gCh
         logic hit;
         logic [24:0] prod;
         logic [13:0] sum;
         assign hit = chWrite && (execCmd.channelAddressField == 5'(g));
         assign prod = {1'b0, inputData[g]} * {1'b0, gainReg[g]};
         assign sum = {2'b00, prod[24:13]} + {2'b00, offsetReg[g]}
                      - {2'b00, `DMC_OFFS_ZERO};
         always_ff @(posedge clk or posedge reset) begin
            if (reset) begin
               inputData[g] <= 12'h000;
               gainReg[g]   <= `DMC_GAIN_FULL;
               offsetReg[g] <= `DMC_OFFS_ZERO;
               corrected[g] <= 12'h000;
               pendCalc[g]  <= 1'b0;
               dirty[g]     <= 1'b0;
            end else if (state == ST_RESET && timer == 32'h0) begin
               inputData[g] <= 12'h000;
               gainReg[g]   <= `DMC_GAIN_FULL;
               offsetReg[g] <= `DMC_OFFS_ZERO;
               corrected[g] <= 12'h000;
               pendCalc[g]  <= 1'b0;
               dirty[g]     <= 1'b0;
            end else begin
               if (hit) begin
                  case ({execCmd.registerSelectHigh,
                         execCmd.registerSelectLow})
                     2'b11:   inputData[g] <= execCmd.data;
                     2'b01:   gainReg[g]   <= execCmd.data;
                     default: offsetReg[g] <= execCmd.data;
                  endcase
               end
               if (state == ST_CALC && timer == 32'h1 && pendCalc[g]) begin
                  corrected[g] <= sum[13] ? 12'h000 :
                                  (sum[12] ? 12'hFFF : sum[11:0]);
               end
               // Set wins over clear of the dirty mark
               if (state == ST_CALC && timer == 32'h1 && pendCalc[g]) begin
                  dirty[g] <= 1'b1;
               end else if (dacWriteStrobe && dacWriteChannel == 5'(g)) begin
                  dirty[g] <= 1'b0;
               end
               if (hit) begin
                  pendCalc[g] <= 1'b1;
               end else if (state == ST_CALC && timer == 32'h1) begin
                  pendCalc[g] <= 1'b0;
               end
            end
         end
      end
   endgenerate

   // SFR commands
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         clearCode <= 12'h000;
         ctrlReg   <= `DMC_CTRL_RESET;
         monSource <= `DMC_MON_OFF;
         powerDown <= 1'b0;
      end else if (state == ST_RESET && timer == 32'h0) begin
         clearCode <= 12'h000;
         ctrlReg   <= `DMC_CTRL_RESET;
         monSource <= `DMC_MON_OFF;
         powerDown <= 1'b0;
      end else if (execValid && isSfr && !execCmd.readNotWrite) begin
         case (execCmd.channelAddressField)
            `DMC_SFR_CLRCODE: if (!powerDown) clearCode <= execCmd.data;
            `DMC_SFR_CTRL:    if (!powerDown) ctrlReg <= execCmd.data;
            `DMC_SFR_MONITOR: if (!powerDown) begin
               monSource <= execCmd.data[11:6];
            end
            `DMC_SFR_PDOWN:   powerDown <= 1'b1;
            `DMC_SFR_PUP:     powerDown <= 1'b0;
            default:          powerDown <= powerDown;
         endcase
      end
   end

   // Monitor mux control; undefined codes leave the mux off
   logic monValid;
   assign monValid = (monSource <= `DMC_CH_LAST) ||
                     (monSource >= `DMC_MON_EXT_LO &&
                      monSource <= `DMC_MON_EXT_HI);
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         monitorSelect       <= `DMC_MON_OFF;
         monitorOutputEnable <= 1'b0;
      end else begin
         monitorSelect       <= monSource;
         monitorOutputEnable <= ctrlReg[`DMC_CR_MONEN]
                                && monSource != `DMC_MON_OFF
                                && monValid && !blocked;
      end
   end

   // Sequencer: power-on, reset, clear, calculation
   logic anyPend;
   assign anyPend = |pendCalc;
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         state <= ST_POR;
         timer <= 32'(`DMC_POR_CYC);
      end else if (rstFall) begin
         state <= ST_RESET;
         timer <= 32'(RESET_CYC - 1);
      end else begin
         case (state)
            ST_POR, ST_RESET: begin
               if (timer == 32'h0) begin
                  state <= ST_IDLE;
               end else begin
                  timer <= timer - 32'h1;
               end
            end
            ST_CLEAR: begin
               if (timer == 32'h0) begin
                  state <= ST_IDLE;
               end else begin
                  timer <= timer - 32'h1;
               end
            end
            ST_IDLE: begin
               if (clrFall) begin
                  state <= ST_CLEAR;
                  timer <= 32'(`DMC_CLEAR_CYC - 1);
               end else if (anyPend) begin
                  state <= ST_CALC;
                  timer <= 32'(`DMC_CALC_CYC);
               end
            end
            ST_CALC: begin
               if (clrFall) begin
                  state <= ST_CLEAR;
                  timer <= 32'(`DMC_CLEAR_CYC - 1);
               end else if (timer == 32'h1) begin
                  state <= ST_IDLE;
               end else begin
                  timer <= timer - 32'h1;
               end
            end
            default: begin
               state <= ST_POR;
               timer <= 32'(`DMC_POR_CYC);
            end
         endcase
      end
   end

   // Queue-enable sampled at end of power-on, reset and clear
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         qEnabled <= 1'b0;
      end else if (state != ST_IDLE && state != ST_CALC
                   && timer == 32'h0) begin
         qEnabled <= qeS[1];
      end
   end

   logic busyNow;
   assign busyNow = (state != ST_IDLE) || anyPend || !fifoEmpty;
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         busy_n   <= 1'b0;
         busyPrev <= 1'b1;
      end else begin
         busy_n   <= !busyNow;
         busyPrev <= busyNow;
      end
   end

   // Load request, scan of dirty channels
   logic ldPrev;
   logic scanning;
   logic [5:0] bcastCnt;
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         ldPrev      <= 1'b0;
         loadPending <= 1'b0;
      end else begin
         ldPrev <= ldLow;
         if (blocked) begin
            loadPending <= 1'b0;
         end else if (ldLow && (!ldPrev || (busyPrev && !busyNow))) begin
            loadPending <= 1'b1;
         end else if (scanning && calcCh == 5'h1F) begin
            loadPending <= 1'b0;
         end
      end
   end
   assign scanning = loadPending && !busyNow;

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         calcCh          <= 5'h00;
         bcastCnt        <= 6'h00;
         dacWriteStrobe  <= 1'b0;
         dacWriteChannel <= 5'h00;
         dacWriteData    <= 12'h000;
      end else if (state == ST_CLEAR && timer == 32'h0) begin
         dacWriteStrobe  <= 1'b0;
      end else if (state == ST_CLEAR || state == ST_RESET) begin
         // Broadcast once: clear code or zero to each channel
         dacWriteStrobe  <= !bcastCnt[5];
         dacWriteChannel <= bcastCnt[4:0];
         dacWriteData    <= (state == ST_CLEAR) ? clearCode : 12'h000;
         bcastCnt        <= bcastCnt + {5'h00, !bcastCnt[5]};
      end else if (scanning) begin
         bcastCnt        <= 6'h00;
         dacWriteStrobe  <= dirty[calcCh];
         dacWriteChannel <= calcCh;
         dacWriteData    <= corrected[calcCh];
         calcCh          <= calcCh + 5'h01;
      end else begin
         dacWriteStrobe  <= 1'b0;
         calcCh          <= 5'h00;
         bcastCnt        <= 6'h00;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         amplifierEnable <= 1'b0;
         amplifierLoad   <= 1'b0;
      end else begin
         amplifierEnable <= !(powerDown || pdS[1]) && state != ST_POR;
         amplifierLoad   <= (powerDown || pdS[1])
                            && !ctrlReg[`DMC_CR_PDHIZ];
      end
   end

   // Avalon slave: one wait cycle on reads, writes never wait
   logic rdDone;
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         rdDone      <= 1'b0;
         avsReadData <= 32'h0;
      end else begin
         rdDone <= avsRead && !rdDone;
         case (avsAddress)
            `DMC_ADDR_CTRL:    avsReadData <= {20'h0, ctrlReg};
            `DMC_ADDR_CLRCODE: avsReadData <= {20'h0, clearCode};
            `DMC_ADDR_STATUS:  avsReadData <= {6'h0, fifoCount, 2'b00,
                                              monSource, 3'b000, state,
                                              qEnabled, !busyNow};
            default:           avsReadData <= 32'h0;
         endcase
      end
   end
   assign avsWaitRequest = avsRead && !rdDone;
endmodule
`default_nettype wire

// file: dmc_core_properties.sv
// Purpose: port-level timing checks of the DAC control block
// Assumes: one clock, reset async active high
// Notes:   windows allow for the two-stage pin synchronisers
`timescale 1ns/1ns
`default_nettype none
module dmc_core_properties #(
   parameter int RESET_CYC = 27000
) (
   input wire logic        clk,
   input wire logic        reset,
   input wire logic [3:0]  avsAddress,
   input wire logic        avsWrite,
   input wire logic [31:0] avsWriteData,
   input wire logic        avsWaitRequest,
   input wire logic        resetPin_n,
   input wire logic        asyncClearInput_n,
   input wire logic        powerDownPin,
   input wire logic        busy_n,
   input wire logic [5:0]  monitorSelect,
   input wire logic        monitorOutputEnable,
   input wire logic        amplifierEnable
);
   localparam int BUSY_MAX = (RESET_CYC > 3200 ? RESET_CYC : 3200) + 16;
   int busyLow;
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   // Longest legal busy stretch is a pin reset or a clear
   always_ff @(posedge clk or posedge reset) begin
      if (reset) busyLow <= 0;
      else if (busy_n) busyLow <= 0;
      else busyLow <= busyLow + 1;
   end
   property p_pinReset;
      $fell(resetPin_n) |-> ##[1:8] !busy_n;
   endproperty
   a_pinReset: assert property (p_pinReset)
      else $error("busy not low after reset pin fall");
   property p_clearBusy;
      $fell(asyncClearInput_n) |-> ##[1:8] !busy_n;
   endproperty
   a_clearBusy: assert property (p_clearBusy)
      else $error("busy not low after clear pin fall");
   property p_busyBound;
      !busy_n |-> busyLow <= BUSY_MAX;
   endproperty
   a_busyBound: assert property (p_busyBound)
      else $error("busy held low too long");
   property p_calcBusy;
      avsWrite && !avsWaitRequest && avsAddress == 4'h8 && busy_n
         && avsWriteData[18:17] == 2'b11 |-> ##[1:4] !busy_n;
   endproperty
   a_calcBusy: assert property (p_calcBusy)
      else $error("no busy after data write");
   property p_porBusy;
      $past(reset) && !reset |-> !busy_n;
   endproperty
   a_porBusy: assert property (p_porBusy)
      else $error("busy high right after power-on");
   property p_porMonOff;
      $past(reset) && !reset |-> !monitorOutputEnable;
   endproperty
   a_porMonOff: assert property (p_porMonOff)
      else $error("monitor driven after power-on");
   property p_monOff;
      monitorSelect == 6'h3F && $past(monitorSelect) == 6'h3F
         |-> !monitorOutputEnable;
   endproperty
   a_monOff: assert property (p_monOff)
      else $error("monitor driven with source 63");
   property p_monUndef;
      monitorSelect inside {6'h20, 6'h21, 6'h3E}
         && $past(monitorSelect) == monitorSelect |-> !monitorOutputEnable;
   endproperty
   a_monUndef: assert property (p_monUndef)
      else $error("monitor driven with undefined source");
   property p_selFromCmd;
      $changed(monitorSelect) && busy_n && $past(busy_n) |->
         ($past(avsWrite) && monitorSelect == $past(avsWriteData[11:6]))
         || ($past(avsWrite, 2)
            && monitorSelect == $past(avsWriteData[11:6], 2));
   endproperty
   a_selFromCmd: assert property (p_selFromCmd)
      else $error("monitor source changed without command");
   property p_pdown;
      powerDownPin [*4] |-> !amplifierEnable;
   endproperty
   a_pdown: assert property (p_pdown)
      else $error("amplifier on in power-down");
endmodule
bind dmc_core dmc_core_properties #(.RESET_CYC(RESET_CYC)) uProps (
   .clk(clk), .reset(reset), .avsAddress(avsAddress), .avsWrite(avsWrite),
   .avsWriteData(avsWriteData), .avsWaitRequest(avsWaitRequest),
   .resetPin_n(resetPin_n), .asyncClearInput_n(asyncClearInput_n),
   .powerDownPin(powerDownPin), .busy_n(busy_n),
   .monitorSelect(monitorSelect), .monitorOutputEnable(monitorOutputEnable),
   .amplifierEnable(amplifierEnable));
`default_nettype wire

// file: dmc_host_pins.sv
// Purpose: host-side model of the control pins
// Assumes: pins change right after a clock edge
// Notes:   pulses last 4 cycles to pass the synchronisers
`timescale 1ns/1ns
`default_nettype none
module dmc_host_pins (
   input  wire logic clk,
   output var logic  resetPin_n,
   output var logic  asyncClearInput_n,
   output var logic  dacLoadStrobe_n,
   output var logic  queueEnablePin,
   output var logic  parallelMode,
   output var logic  powerDownPin
);
   initial begin
      resetPin_n = 1'b1;
      asyncClearInput_n = 1'b1;
      dacLoadStrobe_n = 1'b1;
      queueEnablePin = 1'b0;
      parallelMode = 1'b1;
      powerDownPin = 1'b0;
   end
   task automatic pulseClear();
      asyncClearInput_n <= 1'b0;
      repeat (4) @(posedge clk);
      asyncClearInput_n <= 1'b1;
   endtask
   task automatic pulseLoad();
      dacLoadStrobe_n <= 1'b0;
      repeat (4) @(posedge clk);
      dacLoadStrobe_n <= 1'b1;
   endtask
   task automatic setLoad(input logic v);
      dacLoadStrobe_n <= v;
   endtask
   task automatic setReset(input logic v);
      resetPin_n <= v;
   endtask
   task automatic setPower(input logic v);
      powerDownPin <= v;
   endtask
   task automatic setQueue(input logic v);
      queueEnablePin <= v;
   endtask
endmodule
`default_nettype wire

// file: tb_dac_update_and_monitor_control.sv
// Purpose: directed bench of the DAC update and monitor control block
// Assumes: queue on only in the last test, command in bits 19..0
// Notes:   pin reset sequence shortened to 50 cycles
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin mismatches++; \
   $display("unexpected at %0t got %0h exp %0h", $time, (a), (e)); end end
module tb_dac_update_and_monitor_control
   import dmc_pkg::*;
;
   logic        clk = 1'b0;
   logic        reset = 1'b1;
   logic [3:0]  avsAddress = 4'h0;
   logic        avsRead = 1'b0;
   logic        avsWrite = 1'b0;
   logic [31:0] avsWriteData = 32'h0;
   logic [31:0] avsReadData, rd;
   logic        avsWaitRequest, resetPin_n, asyncClearInput_n;
   logic        dacLoadStrobe_n, queueEnablePin, parallelMode, powerDownPin;
   logic        busy_n, monitorOutputEnable, amplifierEnable, amplifierLoad;
   logic        dacWriteStrobe;
   logic [5:0]  monitorSelect;
   logic [4:0]  dacWriteChannel, lastCh;
   logic [11:0] dacWriteData, lastData;
   logic [5:0]  srcs [4] = '{6'h00, 6'h1F, 6'h22, 6'h25};
   int          nStrobe, mismatches, n_compared;
   always #5 clk = ~clk;
   dmc_host_pins HOST (.clk(clk), .resetPin_n(resetPin_n),
      .asyncClearInput_n(asyncClearInput_n), .dacLoadStrobe_n(dacLoadStrobe_n),
      .queueEnablePin(queueEnablePin), .parallelMode(parallelMode),
      .powerDownPin(powerDownPin));
   dmc_core #(.RESET_CYC(50)) DUT (.clk(clk), .reset(reset),
      .avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite),
      .avsWriteData(avsWriteData), .avsReadData(avsReadData),
      .avsWaitRequest(avsWaitRequest), .resetPin_n(resetPin_n),
      .asyncClearInput_n(asyncClearInput_n), .dacLoadStrobe_n(dacLoadStrobe_n),
      .queueEnablePin(queueEnablePin), .parallelMode(parallelMode),
      .powerDownPin(powerDownPin), .busy_n(busy_n),
      .monitorSelect(monitorSelect), .monitorOutputEnable(monitorOutputEnable),
      .amplifierEnable(amplifierEnable), .amplifierLoad(amplifierLoad),
      .dacWriteStrobe(dacWriteStrobe), .dacWriteChannel(dacWriteChannel),
      .dacWriteData(dacWriteData));
   always @(posedge clk) begin
      if (dacWriteStrobe === 1'b1) begin
         nStrobe <= nStrobe + 1;
         lastCh <= dacWriteChannel;
         lastData <= dacWriteData;
      end
   end
   // Waitrequest and read data are taken at the rising edge
   task automatic busWr(input logic [3:0] a, input logic [31:0] d);
      avsAddress <= a;
      avsWriteData <= d;
      avsWrite <= 1'b1;
      do @(posedge clk); while (avsWaitRequest !== 1'b0);
      avsWrite <= 1'b0;
      @(posedge clk);
   endtask
   task automatic busRd(input logic [3:0] a, output logic [31:0] d);
      avsAddress <= a;
      avsRead <= 1'b1;
      do @(posedge clk); while (avsWaitRequest !== 1'b0);
      d = avsReadData;
      avsRead <= 1'b0;
      @(posedge clk);
   endtask
   task automatic idle();
      repeat (4) @(posedge clk);
      while (busy_n !== 1'b1) @(posedge clk);
      repeat (40) @(posedge clk);
   endtask
   task automatic cmd(input logic sh, input logic sl, input logic [4:0] ad,
                      input logic [11:0] dt);
      dmc_cmd_t c;
      c = '{1'b0, sh, sl, ad, dt};
      busWr(4'h8, {12'h000, c});
      idle();
   endtask
   task automatic done(input string s);
      $display("end of test %s", s);
   endtask
   task automatic complete_run();
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      mismatches++;
      complete_run();
   end
   initial begin
      repeat (12) @(posedge clk);
      reset <= 1'b0;
      idle();
      `CHK(monitorOutputEnable, 1'b0)
      busRd(4'h0, rd);
      `CHK(rd, 32'h0000_0800)
      busRd(4'h4, rd);
      `CHK(rd, 32'h0)
      busRd(4'h2, rd);
      `CHK(rd, 32'h0)
      done("power-on");
      cmd(1'b0, 1'b0, 5'h0A, 12'h17F);
      `CHK(monitorOutputEnable, 1'b0)
      cmd(1'b0, 1'b0, 5'h0C, 12'h880);
      foreach (srcs[i]) begin
         cmd(1'b0, 1'b0, 5'h0A, {srcs[i], 6'h3F});
         `CHK(monitorSelect, srcs[i])
         `CHK(monitorOutputEnable, 1'b1)
      end
      cmd(1'b0, 1'b1, 5'h0A, 12'hFFE);
      `CHK(monitorSelect, 6'h25)
      cmd(1'b0, 1'b0, 5'h0A, 12'hFFF);
      `CHK(monitorOutputEnable, 1'b0)
      cmd(1'b0, 1'b0, 5'h0A, 12'h800);
      `CHK(monitorOutputEnable, 1'b0)
      cmd(1'b0, 1'b0, 5'h0A, 12'h040);
      done("monitor");
      nStrobe = 0;
      HOST.setLoad(1'b0);
      cmd(1'b1, 1'b1, 5'h03, 12'h123);
      `CHK(nStrobe, 2)
      `CHK(lastCh, 5'h0A)
      cmd(1'b1, 1'b1, 5'h03, 12'h124);
      `CHK(nStrobe, 3)
      HOST.setLoad(1'b1);
      idle();
      nStrobe = 0;
      busWr(4'h8, {12'h000, 1'b0, 2'b11, 5'h07, 12'h456});
      HOST.pulseLoad();
      idle();
      `CHK(nStrobe, 1)
      `CHK(lastCh, 5'h07)
      HOST.pulseLoad();
      idle();
      `CHK(nStrobe, 1)
      done("load");
      cmd(1'b0, 1'b0, 5'h01, 12'hABC);
      busRd(4'h4, rd);
      `CHK(rd, 32'h0000_0ABC)
      nStrobe = 0;
      HOST.pulseClear();
      idle();
      `CHK(nStrobe, 32)
      `CHK(lastData, 12'hABC)
      done("clear");
      cmd(1'b0, 1'b0, 5'h0C, 12'h080);
      HOST.setPower(1'b1);
      repeat (6) @(posedge clk);
      `CHK(amplifierEnable, 1'b0)
      `CHK(amplifierLoad, 1'b1)
      HOST.setPower(1'b0);
      repeat (6) @(posedge clk);
      `CHK(monitorSelect, 6'h01)
      `CHK(monitorOutputEnable, 1'b1)
      done("power-down");
      nStrobe = 0;
      HOST.setQueue(1'b1);
      HOST.setReset(1'b0);
      repeat (6) @(posedge clk);
      HOST.pulseLoad();
      idle();
      `CHK(nStrobe, 32)
      `CHK(lastData, 12'h000)
      `CHK(monitorOutputEnable, 1'b0)
      busRd(4'h0, rd);
      `CHK(rd, 32'h0000_0800)
      repeat (100) @(posedge clk);
      `CHK(busy_n, 1'b1)
      cmd(1'b0, 1'b0, 5'h0C, 12'h880);
      cmd(1'b0, 1'b0, 5'h0A, 12'h080);
      `CHK(monitorSelect, 6'h02)
      busRd(4'hC, rd);
      `CHK(rd[1], 1'b1)
      done("reset pin");
      complete_run();
   end
endmodule
`default_nettype wire
